// ===== verilog/cmd_decoder_pkg.sv
// Package: command bits, accumulator widths, pulse timing and carrier struct
package cmd_decoder_pkg;

  localparam int CMD_CLEAR_TS_BIT = 0;
  localparam int CMD_DISABLE_BIT  = 1;
  localparam int CMD_ENABLE_BIT   = 2;
  localparam int CMD_READOUT_BIT  = 3;
  localparam int CMD_PULSE_BIT    = 4;
  localparam int CMD_TOGGLE_BIT   = 5;
  localparam int CMD_TTL1_BIT     = 6;
  localparam int CMD_TTL2_BIT     = 7;

  localparam int CLK_ACC_W    = 48;
  localparam int SINGLE_ACC_W = 32;
  localparam int PAIR_ACC_W   = 32;
  localparam int QUAD_ACC_W   = 16;
  localparam int N_CHAN       = 4;
  localparam int N_PAIR       = 6;
  localparam int N_TRIPLE     = 4;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int PULSE_WIDTH_NS  = 1000;
  localparam int PULSE_CYCLES    = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W     = 8;

  typedef struct packed {
    logic                    valid;
    logic [CLK_ACC_W-1:0]    clocks;
    logic [N_CHAN*SINGLE_ACC_W-1:0] singles;
    logic [N_PAIR*PAIR_ACC_W-1:0]   pairs;
    logic [N_TRIPLE*PAIR_ACC_W-1:0] triples;
    logic [QUAD_ACC_W-1:0]   quad;
  } stats_s;

endpackage : cmd_decoder_pkg

// ===== verilog/event_accum.sv
// Wrapping event accumulator, restarted from the current event on snapshot
`timescale 1ns/1ps
module event_accum #(
  parameter int W = 32
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         inc_i,
  input  wire logic         snap_i,
  output logic [W-1:0]      value_o
);

  logic [W-1:0] acc_r;

  // The event in the snapshot cycle opens the next interval so none is lost
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      acc_r   <= '0;
      value_o <= '0;
    end else if (snap_i) begin
      value_o <= acc_r;
      acc_r   <= W'(inc_i);
    end else begin
      acc_r   <= acc_r + W'(inc_i);
    end
  end

endmodule : event_accum

// ===== verilog/pulse_counter_command_decoder.sv
// Command byte decoder with TTL output control and coincidence accumulators
`timescale 1ns/1ps
module pulse_counter_command_decoder #(
  parameter int PULSE_LEN = cmd_decoder_pkg::PULSE_CYCLES
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic [7:0]                  host_command_byte_i,
  input  wire logic                        host_command_valid_i,
  input  wire logic [3:0]                  chan_in_i,
  output logic [1:0]                       ttl_out_o,
  output logic                             detect_enable_o,
  output logic                             clear_timestamp_o,
  output cmd_decoder_pkg::stats_s          stats_o
);

  localparam int NC = cmd_decoder_pkg::N_CHAN;

  // Input synchroniser, edge history and gated channel hits
  logic [3:0] chan_meta_r;
  logic [3:0] chan_sync_r;
  logic [3:0] chan_prev_r;
  logic [3:0] chan_rise;
  logic [3:0] hit;

  // Command decode
  logic       cmd_go;
  logic [1:0] sel;
  logic       go_clear;
  logic       go_disable;
  logic       go_enable;
  logic       go_readout;
  logic       go_pulse;
  logic       go_toggle;

  // TTL channel control
  logic [1:0] pulse_req;
  logic [1:0] toggle_req;
  logic [1:0] pulse_run;
  logic [1:0] pulse_end;
  logic [cmd_decoder_pkg::PULSE_CNT_W-1:0] pulse_cnt_r [2];

  // Readout strobes
  logic       snap_r;
  logic       snap_pend_r;

  assign cmd_go = host_command_valid_i && (host_command_byte_i != 8'h00);
  assign sel    = {host_command_byte_i[cmd_decoder_pkg::CMD_TTL2_BIT],
                   host_command_byte_i[cmd_decoder_pkg::CMD_TTL1_BIT]};

  // Set flags act together, so one byte may carry several commands; pulse masks toggle and enable beats disable
  assign go_clear   = cmd_go && host_command_byte_i[cmd_decoder_pkg::CMD_CLEAR_TS_BIT];
  assign go_disable = cmd_go && host_command_byte_i[cmd_decoder_pkg::CMD_DISABLE_BIT];
  assign go_enable  = cmd_go && host_command_byte_i[cmd_decoder_pkg::CMD_ENABLE_BIT];
  assign go_readout = cmd_go && host_command_byte_i[cmd_decoder_pkg::CMD_READOUT_BIT];
  assign go_pulse   = cmd_go && host_command_byte_i[cmd_decoder_pkg::CMD_PULSE_BIT];
  assign go_toggle  = cmd_go && host_command_byte_i[cmd_decoder_pkg::CMD_TOGGLE_BIT];

  // Select bits alone do nothing; pulse wins over toggle on a channel
  assign pulse_req  = go_pulse ? sel : 2'b00;
  assign toggle_req = (go_toggle && !go_pulse) ? sel : 2'b00;

  // Pins pass two flip-flops before edge detection
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      chan_meta_r <= 4'h0;
      chan_sync_r <= 4'h0;
    end else begin
      chan_meta_r <= chan_in_i;
      chan_sync_r <= chan_meta_r;
    end
  end

  // History starts at the idle level so reset gives no false edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      chan_prev_r <= 4'h0;
    end else begin
      chan_prev_r <= chan_sync_r;
    end
  end

  assign chan_rise = chan_sync_r & ~chan_prev_r;
  assign hit       = detect_enable_o ? chan_rise : 4'h0;

  // Acquisition mode persists until the host changes it; session close has no effect
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      detect_enable_o <= 1'b0;
    end else if (go_enable) begin
      detect_enable_o <= 1'b1;
    end else if (go_disable) begin
      detect_enable_o <= 1'b0;
    end
  end

  // Clear of the time base leaves only as a one-cycle pulse
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      clear_timestamp_o <= 1'b0;
    end else begin
      clear_timestamp_o <= go_clear;
    end
  end

  // TTL outputs: toggle and pulse act on every selected channel at once
  for (genvar c = 0; c < 2; c++) begin : g_ttl
    assign pulse_run[c] = pulse_cnt_r[c] != '0;
    assign pulse_end[c] = pulse_cnt_r[c] == cmd_decoder_pkg::PULSE_CNT_W'(1);

    // A pulse only starts from a low level; a later pulse or toggle on the channel ends it
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
        pulse_cnt_r[c] <= '0;
      end else if (pulse_req[c] && !ttl_out_o[c]) begin
        pulse_cnt_r[c] <= cmd_decoder_pkg::PULSE_CNT_W'(PULSE_LEN);
      end else if (pulse_req[c] || toggle_req[c]) begin
        pulse_cnt_r[c] <= '0;
      end else if (pulse_run[c]) begin
        pulse_cnt_r[c] <= pulse_cnt_r[c] - 1'b1;
      end
    end

    // Output level: pulse from low rises, pulse on high only falls
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
        ttl_out_o[c] <= 1'b0;
      end else if (pulse_req[c] && ttl_out_o[c]) begin
        ttl_out_o[c] <= 1'b0;
      end else if (pulse_req[c]) begin
        ttl_out_o[c] <= 1'b1;
      end else if (toggle_req[c]) begin
        ttl_out_o[c] <= ~ttl_out_o[c];
      end else if (pulse_end[c]) begin
        ttl_out_o[c] <= 1'b0;
      end
    end
  end

  // Readout snapshot, then one cycle later the valid strobe with captured values
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      snap_r <= 1'b0;
    end else begin
      snap_r <= go_readout;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      snap_pend_r <= 1'b0;
    end else begin
      snap_pend_r <= snap_r;
    end
  end

  assign stats_o.valid = snap_pend_r;

  // Accumulators wrap; the host must read out often enough
  // Clock tally counts only cycles with detection enabled
  event_accum #(.W(cmd_decoder_pkg::CLK_ACC_W)) u_clk_acc (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (detect_enable_o),
    .snap_i    (snap_r),
    .value_o   (stats_o.clocks)
  );

  // Singles per channel, channel 1 in the lowest word
  for (genvar i = 0; i < NC; i++) begin : g_single
    event_accum #(.W(cmd_decoder_pkg::SINGLE_ACC_W)) u_acc (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .inc_i     (hit[i]),
      .snap_i    (snap_r),
      .value_o   (stats_o.singles[i*cmd_decoder_pkg::SINGLE_ACC_W +:
                                  cmd_decoder_pkg::SINGLE_ACC_W])
    );
  end

  // Pairs in order 12,13,14,23,24,34
  for (genvar a = 0; a < NC; a++) begin : g_pa
    for (genvar b = a + 1; b < NC; b++) begin : g_pb
      localparam int P = (a == 0) ? (b - 1) : ((a == 1) ? (b + 1) : 5);
      event_accum #(.W(cmd_decoder_pkg::PAIR_ACC_W)) u_acc (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .inc_i     (hit[a] && hit[b]),
        .snap_i    (snap_r),
        .value_o   (stats_o.pairs[P*cmd_decoder_pkg::PAIR_ACC_W +:
                                  cmd_decoder_pkg::PAIR_ACC_W])
      );
    end
  end

  // Triples in order 123,124,134,234: index t leaves out channel 4-t
  for (genvar t = 0; t < cmd_decoder_pkg::N_TRIPLE; t++) begin : g_tri
    localparam int SKIP = 3 - t;
    logic [3:0] m;
    assign m = hit | (4'h1 << SKIP);
    event_accum #(.W(cmd_decoder_pkg::PAIR_ACC_W)) u_acc (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .inc_i     (&m),
      .snap_i    (snap_r),
      .value_o   (stats_o.triples[t*cmd_decoder_pkg::PAIR_ACC_W +:
                                  cmd_decoder_pkg::PAIR_ACC_W])
    );
  end

  // Four-fold coincidences on the narrowest accumulator
  event_accum #(.W(cmd_decoder_pkg::QUAD_ACC_W)) u_quad_acc (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .inc_i     (&hit),
    .snap_i    (snap_r),
    .value_o   (stats_o.quad)
  );

endmodule : pulse_counter_command_decoder

// ===== testbench/pulse_counter_command_decoder_checker.sv
// Port checker for the command decoder
`timescale 1ns/1ps
module pulse_counter_command_decoder_checker #(
  parameter int PULSE_LEN = 3
) (
  input wire logic                    ref_clk_i,
  input wire logic                    rst_b_i,
  input wire logic [7:0]              host_command_byte_i,
  input wire logic                    host_command_valid_i,
  input wire logic [3:0]              chan_in_i,
  input wire logic [1:0]              ttl_out_o,
  input wire logic                    detect_enable_o,
  input wire logic                    clear_timestamp_o,
  input wire cmd_decoder_pkg::stats_s stats_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic       v = host_command_valid_i;
  wire logic [7:0] b = host_command_byte_i;
  a_zero_byte_idle: assert property (v && b == 8'h00 |=>
    !clear_timestamp_o && $stable(detect_enable_o)) else $error("zero byte changed state");
  a_clear_ts_pulse: assert property (v && b[0] |=> clear_timestamp_o)
    else $error("clear pulse missing");
  a_clear_ts_cause: assert property (clear_timestamp_o |-> $past(v) && $past(b[0]))
    else $error("clear pulse without command");
  a_enable_sets: assert property (v && b[2] |=> detect_enable_o)
    else $error("enable not set");
  a_disable_clears: assert property (v && b[1] && !b[2] |=> !detect_enable_o)
    else $error("disable not applied");
  a_toggle_ch_two: assert property (v && b[5] && !b[4] && b[7] |=>
    ttl_out_o[1] != $past(ttl_out_o[1])) else $error("toggle did not invert");
  a_pulse_high_low: assert property (v && b[4] && b[6] && ttl_out_o[0] |=>
    !ttl_out_o[0]) else $error("pulse on high output not low");
  a_pulse_rise: assert property (v && b[4] && b[7] && !ttl_out_o[1] |=> ttl_out_o[1])
    else $error("pulse did not rise");
  a_readout_valid: assert property (v && b[3] |=> ##1 stats_o.valid)
    else $error("readout valid missing");
  a_valid_cause: assert property (stats_o.valid |->
    $past(host_command_valid_i, 2) && $past(host_command_byte_i[3], 2))
    else $error("valid without readout");
endmodule : pulse_counter_command_decoder_checker

bind pulse_counter_command_decoder pulse_counter_command_decoder_checker #(
  .PULSE_LEN(PULSE_LEN)) i_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .host_command_byte_i(host_command_byte_i), .host_command_valid_i(host_command_valid_i),
  .chan_in_i(chan_in_i), .ttl_out_o(ttl_out_o), .detect_enable_o(detect_enable_o),
  .clear_timestamp_o(clear_timestamp_o), .stats_o(stats_o));

// ===== testbench/host_model.sv
// Host side model issuing command bytes
`timescale 1ns/1ps
module host_model (
  input  wire logic  ref_clk_i,
  output logic [7:0] host_command_byte_o,
  output logic       host_command_valid_o
);
  initial begin
    host_command_byte_o  = 8'h00;
    host_command_valid_o = 1'b0;
  end
  // One whole flag byte per transfer; released data is inverted
  task automatic send(input logic [7:0] b);
    host_command_valid_o <= 1'b1;
    host_command_byte_o  <= b;
    @(posedge ref_clk_i);
    host_command_valid_o <= 1'b0;
    host_command_byte_o  <= ~b;
  endtask : send
endmodule : host_model

// ===== testbench/test_pulse_counter_command_decoder.sv
// Self-checking testbench for the command decoder
`timescale 1ns/1ps
module test_pulse_counter_command_decoder;
  localparam int PL = 3;
  logic                    ref_clk_i = 1'b0;
  logic                    rst_b_i   = 1'b0;
  logic [3:0]              chan_in_i = 4'h0;
  logic [7:0]              cmd;
  logic                    cmd_v;
  logic [1:0]              ttl;
  logic                    en;
  logic                    clr;
  cmd_decoder_pkg::stats_s st;
  int                      n_fail = 0;
  int                      total_checks = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  host_model i_host (.ref_clk_i(ref_clk_i), .host_command_byte_o(cmd),
    .host_command_valid_o(cmd_v));
  pulse_counter_command_decoder #(.PULSE_LEN(PL)) i_dut (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .host_command_byte_i(cmd), .host_command_valid_i(cmd_v),
    .chan_in_i(chan_in_i), .ttl_out_o(ttl), .detect_enable_o(en),
    .clear_timestamp_o(clr), .stats_o(st));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic cmd_chk(input logic [7:0] b, input logic [1:0] et, input logic ee);
    i_host.send(b);
    #1;
    chk(ttl, et);
    chk(en, ee);
    @(posedge ref_clk_i);
  endtask : cmd_chk
  task automatic t_ttl;
    cmd_chk(8'h00, 2'b00, 1'b0);
    cmd_chk(8'hE0, 2'b11, 1'b0);
    cmd_chk(8'hA0, 2'b01, 1'b0);
    cmd_chk(8'hC0, 2'b01, 1'b0);
    cmd_chk(8'h50, 2'b00, 1'b0);
    tick(PL + 2);
    #1 chk(ttl, 2'b00);
    @(posedge ref_clk_i);
    cmd_chk(8'h70, 2'b01, 1'b0);
    tick(PL);
    #1 chk(ttl, 2'b00);
    @(posedge ref_clk_i);
  endtask : t_ttl
  task automatic t_combo;
    cmd_chk(8'h9C, 2'b10, 1'b1);
    #1 chk(st.valid, 1'b1);
    tick(PL - 2);
    #1 chk(ttl[1], 1'b1);
    chk(st.valid, 1'b0);
    @(posedge ref_clk_i);
    #1 chk(ttl[1], 1'b0);
    @(posedge ref_clk_i);
  endtask : t_combo
  task automatic t_counts;
    i_host.send(8'h09);
    #1 chk(clr, 1'b1);
    @(posedge ref_clk_i);
    repeat (3) begin
      chan_in_i <= 4'hF;
      @(posedge ref_clk_i);
      chan_in_i <= 4'h0;
      @(posedge ref_clk_i);
    end
    chan_in_i <= 4'h1;
    @(posedge ref_clk_i);
    chan_in_i <= 4'h0;
    tick(6);
    i_host.send(8'h08);
    @(posedge ref_clk_i);
    #1 chk(st.clocks, 15);
    chk(st.valid, 1'b1);
    chk(clr, 1'b0);
    for (int i = 0; i < 4; i++) chk(st.singles[i*32+:32], (i == 0) ? 32'h4 : 32'h3);
    for (int i = 0; i < 6; i++) chk(st.pairs[i*32+:32], 32'h3);
    for (int i = 0; i < 4; i++) chk(st.triples[i*32+:32], 32'h3);
    chk(st.quad, 16'h3);
    @(posedge ref_clk_i);
    cmd_chk(8'h06, 2'b00, 1'b1);
    cmd_chk(8'h02, 2'b00, 1'b0);
  endtask : t_counts
  initial begin
    tick(16);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    t_ttl();
    t_combo();
    t_counts();
    conclude();
  end
  initial begin
    tick(400);
    n_fail++;
    conclude();
  end
endmodule : test_pulse_counter_command_decoder
